// ---- logic/clock_gen_i2c_control_regs.sv ----
/*
  Two-wire serial target and six control bytes of a six-output clock
  generator, with output enable gating, amplitude select and power-down.
  Assumes scl, sda, enable pins and the power-down pin are asynchronous,
  and outPhase is a same-clock level from the clock synthesis.
*/
`timescale 1ns/1ps

// Functional notes
// - Answer only target address 8'hd6 form.
// - Byte and block reads and writes supported.
// - Block bytes ascend, MSB first, stop anywhere.
// - Single-byte access addresses any index directly.
// - Block write: command, count, data, all acked.
// - Block read returns count then data bytes.
// - Byte write: command, one data, acked.
// - Byte read returns one byte, controller NACKs.
// - Registers load defaults at power-up.
// - Byte 0 reserved read/write, resets zero.
// - Byte 1 enables outputs 0-2, bits 4,2,0.
// - Byte 2 enables outputs 3-5, bits 7,6,5.
// - Byte 4 is byte count, resets six.
// - Byte 5 bit 7 selects programmed amplitude.
// - Amplitude code 300 mV plus 100 mV steps.
// - Output runs only when pin and bit high.
// - Disabled output stops cleanly, rests low.
// - Restart glitch-free within two to six periods.
// - Power-down disables outputs and serial logic.
module clock_gen_i2c_control_regs (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic [5:0] outEnablePin,
  input wire logic powerdown_n,
  input wire logic outPhase,
  output logic clock_out_0,
  output logic clock_out_1,
  output logic clock_out_2,
  output logic clock_out_3,
  output logic clock_out_4,
  output logic clock_out_5,
  output logic [5:0] outputRunning,
  output logic [9:0] swingMillivolts
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0] regs [0:clock_gen_pkg::REG_COUNT-1];
  logic sclMeta, sclS, sclPrev, sdaMeta, sdaS, sdaPrev;
  logic [5:0] pinMeta, pinSync;
  logic pdMeta, pdSync, armed, pdActive;
  logic startCond, stopCond, sclRise, sclFall, byteDone, wrStrobe;
  clock_gen_pkg::bus_state_type state;
  clock_gen_pkg::stage_type stage;
  logic [3:0] bitCnt;
  logic [7:0] shift, txByte, index, remaining, nextByte, firstByte;
  logic byteMode, txPending, masterAck;
  logic [5:0] enableReq;
  logic [5:0] clockOut;

  // Register read with a zero answer past the last byte.
  function automatic logic [7:0] readReg(input logic [7:0] idx);
    if (idx < 8'(clock_gen_pkg::REG_COUNT)) begin
      readReg = regs[idx[2:0]];
    end else begin
      readReg = 8'h00;
    end
  endfunction

  // Enable bits gathered from bytes 1 and 2 into output order.
  function automatic logic [5:0] enableMap(input logic [7:0] low, input logic [7:0] high);
    enableMap = {high[clock_gen_pkg::OUT5_BIT], high[clock_gen_pkg::OUT4_BIT],
                 high[clock_gen_pkg::OUT3_BIT], low[clock_gen_pkg::OUT2_BIT],
                 low[clock_gen_pkg::OUT1_BIT], low[clock_gen_pkg::OUT0_BIT]};
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Every pin passes two flip-flops; only the second is read.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sclMeta <= 1'b1;
      sclS <= 1'b1;
      sdaMeta <= 1'b1;
      sdaS <= 1'b1;
      pinMeta <= 6'h00;
      pinSync <= 6'h00;
      pdMeta <= 1'b0;
      pdSync <= 1'b0;
    end else if (ce) begin
      sclMeta <= sclIn;
      sclS <= sclMeta;
      sdaMeta <= sdaIn;
      sdaS <= sdaMeta;
      pinMeta <= outEnablePin;
      pinSync <= pinMeta;
      pdMeta <= powerdown_n;
      pdSync <= pdMeta;
    end
  end

  // Edge history of the synchronised bus lines.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
    end else if (ce) begin
      sclPrev <= sclS;
      sdaPrev <= sdaS;
    end
  end

  // ----------------------------------------------------------------
  // Supply-good and power-down
  // ----------------------------------------------------------------
  // The pin acts as supply-good until first seen high, then as power-down.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      armed <= 1'b0;
    end else if (ce && pdSync) begin
      armed <= 1'b1;
    end
  end

  assign pdActive = armed & ~pdSync;

  // ----------------------------------------------------------------
  // Bus events
  // ----------------------------------------------------------------
  assign startCond = sclS & sclPrev & sdaPrev & ~sdaS;
  assign stopCond = sclS & sclPrev & ~sdaPrev & sdaS;
  assign sclRise = sclS & ~sclPrev;
  assign sclFall = ~sclS & sclPrev;
  assign byteDone = ~pdActive & (state == clock_gen_pkg::S_RX) & sclFall & (bitCnt == clock_gen_pkg::BITS_PER_BYTE);
  assign wrStrobe = byteDone & (stage == clock_gen_pkg::ST_DATA) & (remaining != 8'h00);
  assign nextByte = readReg(index);
  assign firstByte = byteMode ? nextByte : regs[clock_gen_pkg::IDX_LENGTH[2:0]];
  assign sdaOut = 1'b0;

  // ----------------------------------------------------------------
  // Serial target state machine
  // ----------------------------------------------------------------
  // Start and stop override any byte in flight, as a repeated start must.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state <= clock_gen_pkg::S_IDLE;
      stage <= clock_gen_pkg::ST_ADDR;
      bitCnt <= 4'h0;
      shift <= 8'h00;
      txByte <= 8'h00;
      index <= 8'h00;
      remaining <= 8'h00;
      byteMode <= 1'b0;
      txPending <= 1'b0;
      masterAck <= 1'b0;
      sdaOe <= 1'b0;
    end else if (ce) begin
      if (pdActive) begin
        state <= clock_gen_pkg::S_IDLE;
        sdaOe <= 1'b0;
      end else if (startCond) begin
        state <= clock_gen_pkg::S_RX;
        stage <= clock_gen_pkg::ST_ADDR;
        bitCnt <= 4'h0;
        sdaOe <= 1'b0;
      end else if (stopCond) begin
        state <= clock_gen_pkg::S_IDLE;
        sdaOe <= 1'b0;
      end else begin
        case (state)
          clock_gen_pkg::S_RX: begin
            if (sclRise) begin
              shift <= {shift[6:0], sdaS};
              bitCnt <= bitCnt + 4'h1;
            end else if (byteDone) begin
              bitCnt <= 4'h0;
              state <= clock_gen_pkg::S_RXACK;
              txPending <= 1'b0;
              case (stage)
                clock_gen_pkg::ST_ADDR: begin
                  if (shift[7:1] != clock_gen_pkg::TARGET_ADDR) begin
                    state <= clock_gen_pkg::S_IDLE;
                  end else begin
                    sdaOe <= 1'b1;
                    if (shift[0]) begin
                      txPending <= 1'b1;
                    end else begin
                      stage <= clock_gen_pkg::ST_CMD;
                    end
                  end
                end
                clock_gen_pkg::ST_CMD: begin
                  sdaOe <= 1'b1;
                  index <= {1'b0, shift[6:0]};
                  byteMode <= shift[clock_gen_pkg::CMD_MODE_BIT];
                  remaining <= 8'h01;
                  stage <= shift[clock_gen_pkg::CMD_MODE_BIT] ? clock_gen_pkg::ST_DATA : clock_gen_pkg::ST_COUNT;
                end
                clock_gen_pkg::ST_COUNT: begin
                  sdaOe <= 1'b1;
                  remaining <= shift;
                  stage <= clock_gen_pkg::ST_DATA;
                end
                default: begin
                  if (remaining != 8'h00) begin
                    sdaOe <= 1'b1;
                    remaining <= remaining - 8'h01;
                    index <= index + 8'h01;
                  end else begin
                    state <= clock_gen_pkg::S_IDLE;
                  end
                end
              endcase
            end
          end
          clock_gen_pkg::S_RXACK: begin
            if (sclFall) begin
              if (txPending) begin
                state <= clock_gen_pkg::S_TX;
                txByte <= firstByte;
                sdaOe <= ~firstByte[7];
                if (byteMode) begin
                  index <= index + 8'h01;
                end
              end else begin
                state <= clock_gen_pkg::S_RX;
                sdaOe <= 1'b0;
              end
            end
          end
          clock_gen_pkg::S_TX: begin
            if (sclRise) begin
              bitCnt <= bitCnt + 4'h1;
            end else if (sclFall) begin
              if (bitCnt == clock_gen_pkg::BITS_PER_BYTE) begin
                bitCnt <= 4'h0;
                sdaOe <= 1'b0;
                state <= clock_gen_pkg::S_TXACK;
              end else begin
                txByte <= {txByte[6:0], 1'b0};
                sdaOe <= ~txByte[6];
              end
            end
          end
          clock_gen_pkg::S_TXACK: begin
            if (sclRise) begin
              masterAck <= ~sdaS;
            end else if (sclFall) begin
              if (masterAck) begin
                state <= clock_gen_pkg::S_TX;
                txByte <= nextByte;
                sdaOe <= ~nextByte[7];
                index <= index + 8'h01;
              end else begin
                state <= clock_gen_pkg::S_IDLE;
              end
            end
          end
          default: begin
            sdaOe <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  // Every bit, reserved ones included, stores and reads back; writes past
  // the last byte are acknowledged but dropped.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int i = 0; i < clock_gen_pkg::REG_COUNT; i++) begin
        regs[i] <= clock_gen_pkg::REG_RESET[i*8 +: 8];
      end
    end else if (ce && wrStrobe && index < 8'(clock_gen_pkg::REG_COUNT)) begin
      regs[index[2:0]] <= shift;
    end
  end

  // ----------------------------------------------------------------
  // Output enables, gating and amplitude
  // ----------------------------------------------------------------
  // Pin and bit must both be high; outputs wait for supply-good.
  assign enableReq = enableMap(regs[clock_gen_pkg::IDX_ENABLE_LOW[2:0]],
                               regs[clock_gen_pkg::IDX_ENABLE_HIGH[2:0]])
                     & pinSync & {6{armed & ~pdActive}};

  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : gates
      output_gate gate (
        .clk(clk),
        .rst_b(rst_b),
        .ce(ce),
        .request(enableReq[g]),
        .outPhase(outPhase),
        .clockOut(clockOut[g]),
        .running(outputRunning[g])
      );
    end
  endgenerate

  assign clock_out_0 = clockOut[0];
  assign clock_out_1 = clockOut[1];
  assign clock_out_2 = clockOut[2];
  assign clock_out_3 = clockOut[3];
  assign clock_out_4 = clockOut[4];
  assign clock_out_5 = clockOut[5];

  // Amplitude in millivolts; the code field is ignored while bit 7 is low.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      swingMillivolts <= clock_gen_pkg::SWING_DEFAULT_MV;
    end else if (ce) begin
      if (regs[clock_gen_pkg::IDX_SWING[2:0]][clock_gen_pkg::SWING_SEL_BIT]) begin
        swingMillivolts <= clock_gen_pkg::SWING_BASE_MV + clock_gen_pkg::SWING_STEP_MV
          * 10'(regs[clock_gen_pkg::IDX_SWING[2:0]][clock_gen_pkg::SWING_CODE_LSB +: 3]);
      end else begin
        swingMillivolts <= clock_gen_pkg::SWING_DEFAULT_MV;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence addrMiss;
    ce && byteDone && stage == clock_gen_pkg::ST_ADDR && shift[7:1] != clock_gen_pkg::TARGET_ADDR;
  endsequence
  sequence readTurn;
    ce && !pdActive && !startCond && !stopCond && state == clock_gen_pkg::S_RXACK && sclFall && txPending;
  endsequence

  chk_addr_ignored: assert property (addrMiss |=> state == clock_gen_pkg::S_IDLE && !sdaOe)
    else $error("target answered a foreign address");
  chk_count_acked: assert property (ce && byteDone && stage == clock_gen_pkg::ST_COUNT
    |=> sdaOe && stage == clock_gen_pkg::ST_DATA)
    else $error("byte count not acknowledged");
  chk_write_lands: assert property (ce && wrStrobe && index < 8'h06 |=> regs[$past(index[2:0])] == $past(shift))
    else $error("written byte not stored at its index");
  chk_index_ascends: assert property (ce && wrStrobe |=> index == $past(index) + 8'h01)
    else $error("write index did not step up");
  chk_count_first: assert property (readTurn and !byteMode |=> txByte == regs[4] && state == clock_gen_pkg::S_TX)
    else $error("block read did not start with the byte count");
  chk_nack_ends: assert property (ce && !pdActive && !startCond && !stopCond && state == clock_gen_pkg::S_TXACK
    && sclFall && !masterAck |=> state == clock_gen_pkg::S_IDLE && !sdaOe)
    else $error("read went on after a missing acknowledge");
  chk_powerdown_quiet: assert property (ce && pdActive |=> state == clock_gen_pkg::S_IDLE && !sdaOe ##1 !sdaOe)
    else $error("serial logic active in power-down");
  chk_enable_pair: assert property (ce && !pinSync[0] |-> !enableReq[0] ##1 !enableReq[0] || pinSync[0])
    else $error("output requested with its pin low");
  chk_swing_code: assert property (ce && regs[5][7] && regs[5][6:4] == 3'h7 |=> swingMillivolts == 10'h3e8)
    else $error("top amplitude code not 1000 mV");

endmodule // clock_gen_i2c_control_regs

// ---- pkg/clock_gen_pkg.sv ----
/*
  Constants and types for the clock generator's two-wire control block:
  target address, register indices, reset values, field positions and
  the state types of the serial target.
  Assumes it is compiled before every logic/ file that names it.
*/
package clock_gen_pkg;

  // ----------------------------------------------------------------
  // Serial target
  // ----------------------------------------------------------------
  localparam logic [6:0] TARGET_ADDR = 7'h6b;  // Byte form 8'hd6 with the write bit.
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int CMD_MODE_BIT = 7;  // Command bit 7 high selects single-byte access.

  // ----------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------
  localparam int REG_COUNT = 6;
  localparam logic [7:0] IDX_SPARE = 8'h00;
  localparam logic [7:0] IDX_ENABLE_LOW = 8'h01;
  localparam logic [7:0] IDX_ENABLE_HIGH = 8'h02;
  localparam logic [7:0] IDX_REV_VENDOR = 8'h03;
  localparam logic [7:0] IDX_LENGTH = 8'h04;
  localparam logic [7:0] IDX_SWING = 8'h05;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SPARE_RESET = 8'h00;
  localparam logic [7:0] ENABLE_LOW_RESET = 8'h15;
  localparam logic [7:0] ENABLE_HIGH_RESET = 8'he0;
  localparam logic [7:0] REV_VENDOR_RESET = 8'h21;  // Arbitrary revision and maker code.
  localparam logic [7:0] LENGTH_RESET = 8'h06;
  localparam logic [7:0] SWING_RESET = 8'hd8;
  localparam logic [47:0] REG_RESET = {SWING_RESET, LENGTH_RESET, REV_VENDOR_RESET,
                                       ENABLE_HIGH_RESET, ENABLE_LOW_RESET, SPARE_RESET};

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int OUT0_BIT = 4;
  localparam int OUT1_BIT = 2;
  localparam int OUT2_BIT = 0;
  localparam int OUT3_BIT = 7;
  localparam int OUT4_BIT = 6;
  localparam int OUT5_BIT = 5;
  localparam int SWING_SEL_BIT = 7;
  localparam int SWING_CODE_LSB = 4;

  // ----------------------------------------------------------------
  // Output swing and gating
  // ----------------------------------------------------------------
  localparam logic [9:0] SWING_BASE_MV = 10'h12c;     // 300 mV at code 000.
  localparam logic [9:0] SWING_STEP_MV = 10'h064;     // 100 mV per code step.
  localparam logic [9:0] SWING_DEFAULT_MV = 10'h2bc;  // Plain default amplitude.
  localparam logic [2:0] START_PERIODS = 3'h3;        // Output periods before restart.

  typedef enum {S_IDLE, S_RX, S_RXACK, S_TX, S_TXACK} bus_state_type;
  typedef enum {ST_ADDR, ST_CMD, ST_COUNT, ST_DATA} stage_type;

endpackage

// ---- logic/output_gate.sv ----
/*
  Glitch-free gate for one clock output.
  Assumes outPhase is the synthesised output clock as a level on clk.
*/
`timescale 1ns/1ps

module output_gate (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic request,
  input wire logic outPhase,
  output logic clockOut,
  output logic running
);

  logic phasePrev;
  logic [2:0] startCount;
  logic tick;
  logic next_running;

  // A tick is a falling phase edge, so gating changes only in the low half.
  assign tick = phasePrev & ~outPhase;

  // Start after a few whole periods of request, stop at the next low half.
  always_comb begin
    next_running = running;
    if (tick) begin
      if (!request) begin
        next_running = 1'b0;
      end else if (!running && startCount == clock_gen_pkg::START_PERIODS - 3'h1) begin
        next_running = 1'b1;
      end
    end
  end

  // Period counter for the restart delay.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      startCount <= 3'h0;
    end else if (ce) begin
      if (!request || running) begin
        startCount <= 3'h0;
      end else if (tick) begin
        startCount <= startCount + 3'h1;
      end
    end
  end

  // Gated clock and run state; a stopped output rests low.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      phasePrev <= 1'b0;
      running <= 1'b0;
      clockOut <= 1'b0;
    end else if (ce) begin
      phasePrev <= outPhase;
      running <= next_running;
      clockOut <= next_running & outPhase;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_stop_on_drop: assert property (ce && running && tick && !request |=> !running)
    else $error("output kept running after its enable dropped");
  chk_rest_low: assert property (!running |-> !clockOut)
    else $error("stopped output is not low");
  chk_start_delay: assert property (ce && !running && next_running |-> request && startCount == 3'h2)
    else $error("output restarted without the full delay");

endmodule // output_gate

// ---- tb/i2c_ctrl_model.sv ----
/*
  Behavioural two-wire bus controller that sits on the far side of the
  control block. It drives the bus clock and pulls the data wire low.
  Assumes the bench resolves the wire as the inverse of both pull-downs.
*/
`timescale 1ns/1ps

module i2c_ctrl_model (
  input wire logic clk,
  input wire logic sdaWire,
  output logic scl,
  output logic pull
);
  // Idle bus: clock high, data released to the pull-up level.
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask

  // One bit slot; data changes only while the clock is low.
  task automatic bitx(input logic b, output logic s);
    pull = !b;
    hold(8);
    scl = 1'b1;
    hold(4);
    s = sdaWire;
    hold(4);
    scl = 1'b0;
  endtask

  // Data falls while the clock is high; also serves as a repeated start.
  task automatic start;
    pull = 1'b0;
    hold(4);
    scl = 1'b1;
    hold(8);
    pull = 1'b1;
    hold(8);
    scl = 1'b0;
  endtask

  task automatic stop;
    pull = 1'b1;
    hold(8);
    scl = 1'b1;
    hold(8);
    pull = 1'b0;
    hold(8);
  endtask

  // Byte out, most significant bit first, then sample the target's answer.
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bitx(d[i], s);
    bitx(1'b1, s);
    ack = !s;
  endtask

  // Byte in; the last byte of a read is not acknowledged.
  task automatic rbyte(input logic ackIt, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(!ackIt, s);
  endtask
endmodule // i2c_ctrl_model

// ---- tb/tb_clock_gen_i2c_control_regs.sv ----
/*
  Self-checking bench for the control block: register access over the
  two-wire bus, output gating, amplitude select and power-down.
  Assumes the controller model and the design package are compiled first.
*/
`timescale 1ns/1ps

module tb_clock_gen_i2c_control_regs;
  logic clk = 1'b0;
  logic rst_b;
  logic [5:0] outEnablePin;
  logic powerdown_n;
  logic [2:0] ph = 3'h0;
  logic scl, pull, sdaOe;
  wire sdaWire = ~(sdaOe | pull);
  logic [5:0] outputRunning;
  logic [9:0] swingMillivolts;
  logic c0, c1, c2, c3, c4, c5;
  int checks = 0;
  int n_mismatch = 0;

  // Clock and a synthesised output phase of eight cycles.
  always #25 clk = ~clk;
  always @(negedge clk) ph <= ph + 3'h1;

  i2c_ctrl_model m (.clk(clk), .sdaWire(sdaWire), .scl(scl), .pull(pull));

  clock_gen_i2c_control_regs u_dut (.clk(clk), .rst_b(rst_b), .ce(1'b1), .sclIn(scl), .sdaIn(sdaWire),
    .sdaOut(), .sdaOe(sdaOe), .outEnablePin(outEnablePin), .powerdown_n(powerdown_n), .outPhase(ph[2]),
    .clock_out_0(c0), .clock_out_1(c1), .clock_out_2(c2), .clock_out_3(c3), .clock_out_4(c4),
    .clock_out_5(c5), .outputRunning(outputRunning), .swingMillivolts(swingMillivolts));

  task automatic cmp(input string nm, input logic [9:0] e, input logic [9:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic xfer(input logic [7:0] d, input logic ackExp, input string nm);
    logic a;
    m.wbyte(d, a);
    cmp(nm, {9'h000, ackExp}, {9'h000, a});
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    m.start();
    xfer(8'hd6, 1'b1, "addr");
    xfer(8'h80 | idx, 1'b1, "cmd");
    xfer(d, 1'b1, "data");
    m.stop();
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    logic [7:0] v;
    m.start();
    xfer(8'hd6, 1'b1, "addr");
    xfer(8'h80 | idx, 1'b1, "cmd");
    m.start();
    xfer(8'hd7, 1'b1, "raddr");
    m.rbyte(1'b0, v);
    m.stop();
    cmp("read", {2'h0, e}, {2'h0, v});
  endtask

  // Reset values read back in one block read starting at index 0.
  task automatic t_reset;
    logic [7:0] v;
    logic [47:0] e;
    e = {8'hd8, 8'h06, clock_gen_pkg::REV_VENDOR_RESET, 8'he0, 8'h15, 8'h00};
    repeat (60) @(negedge clk);
    cmp("running", 10'h03f, {4'h0, outputRunning});
    cmp("swing", 10'h320, swingMillivolts);
    m.start();
    xfer(8'hd6, 1'b1, "addr");
    xfer(8'h00, 1'b1, "cmd");
    m.start();
    xfer(8'hd7, 1'b1, "raddr");
    m.rbyte(1'b1, v);
    cmp("count", 10'h006, {2'h0, v});
    for (int i = 0; i < 6; i++) begin
      m.rbyte(i < 5, v);
      cmp("regs", {2'h0, e[8*i+:8]}, {2'h0, v});
    end
    m.stop();
  endtask

  // Foreign address ignored; reserved bits store and read back.
  task automatic t_byte;
    m.start();
    xfer(8'hd4, 1'b0, "badaddr");
    m.stop();
    wr(8'h00, 8'h5a);
    rd(8'h00, 8'h5a);
    wr(8'h02, 8'h1f);
    rd(8'h02, 8'h1f);
    repeat (30) @(negedge clk);
    cmp("hi_off", 10'h007, {4'h0, outputRunning});
  endtask

  // Block write of two bytes from index 1; a third byte is refused.
  task automatic t_block;
    int hi;
    m.start();
    xfer(8'hd6, 1'b1, "addr");
    xfer(8'h01, 1'b1, "cmd");
    xfer(8'h02, 1'b1, "count");
    xfer(8'h04, 1'b1, "d1");
    xfer(8'he0, 1'b1, "d2");
    xfer(8'h15, 1'b0, "d3");
    m.stop();
    repeat (30) @(negedge clk);
    cmp("lo_mask", 10'h03a, {4'h0, outputRunning});
    hi = 0;
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      cmp("out0_low", 10'h000, {9'h000, c0});
      cmp("out2_low", 10'h000, {9'h000, c2});
      hi = hi + int'(c1) + int'(c3) + int'(c4) + int'(c5);
    end
    // Each running output is high for half of its eight-cycle period.
    cmp("run_highs", 10'h010, 10'(hi));
    wr(8'h01, 8'h15);
  endtask

  // Every amplitude code, then the default amplitude.
  task automatic t_swing;
    for (int c = 0; c < 8; c++) begin
      wr(8'h05, {1'b1, 3'(c), 4'h8});
      repeat (4) @(negedge clk);
      cmp("swing", 10'h12c + 10'h064 * 10'(c), swingMillivolts);
    end
    wr(8'h05, 8'h50);
    repeat (4) @(negedge clk);
    cmp("swing_def", 10'h2bc, swingMillivolts);
  endtask

  // Pin gating, restart delay, and power-down shutting the bus.
  task automatic t_gate;
    int n;
    outEnablePin = 6'h3e;
    repeat (30) @(negedge clk);
    cmp("pin_off", 10'h03e, {4'h0, outputRunning});
    cmp("out0_rest", 10'h000, {9'h000, c0});
    outEnablePin = 6'h3f;
    n = 0;
    while (outputRunning[0] !== 1'b1 && n < 80) begin
      @(negedge clk);
      n++;
    end
    // Two to six periods of eight cycles, plus the pin synchroniser delay.
    cmp("restart", 10'h001, {9'h000, (n >= 16 && n <= 52)});
    powerdown_n = 1'b0;
    repeat (30) @(negedge clk);
    cmp("pd_off", 10'h000, {4'h0, outputRunning});
    m.start();
    xfer(8'hd6, 1'b0, "pd_addr");
    m.stop();
    powerdown_n = 1'b1;
    repeat (70) @(negedge clk);
    cmp("pd_back", 10'h03f, {4'h0, outputRunning});
    rd(8'h02, 8'he0);
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Watchdog well beyond the expected run of about 11000 cycles.
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    wrap_up();
  end

  // Main sequence: two cycles of reset, then the scenarios.
  initial begin
    rst_b = 1'b0;
    outEnablePin = 6'h3f;
    powerdown_n = 1'b1;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    repeat (10) @(negedge clk);
    t_reset();
    t_byte();
    t_block();
    t_swing();
    t_gate();
    wrap_up();
  end
endmodule // tb_clock_gen_i2c_control_regs
